/* File: common/tfp_regs.svh */
// Timing counts and reset values of the programmer control block.
// Assumes a 10 MHz system clock.
`ifndef TFP_REGS_SVH
`define TFP_REGS_SVH
`define TFP_CLK_HZ 10000000
`define TFP_MS_CYC(ms) ((ms) * (`TFP_CLK_HZ / 1000))
`define TFP_BEEP_MS 300
`define TFP_BUTTON_MS 300
`define TFP_START_MS 500
`define TFP_MAX_FLASH_KB 10'h200
`define TFP_ALLOW_RST 32'h000F_4240
`define TFP_BOOT_BEEPS 3'h5
`define TFP_FAIL_BEEPS 3'h3
`define TFP_TCLK_HALF 4'h5
`endif

/* File: common/tfp_pkg.sv */
// Types shared by the programmer control block.
// Assumes tfp_regs.svh supplies the numeric constants.
package tfp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BOOT  = 3'b001,
    ST_READY = 3'b010,
    ST_PROG  = 3'b011,
    ST_PASS  = 3'b100,
    ST_FAIL  = 3'b101
  } tfp_state_e;
  typedef enum logic {
    OP_PROGRAM = 1'b0,
    OP_VERIFY  = 1'b1
  } tfp_op_e;
  typedef struct packed {
    logic prog_if_enable;
    logic target_emu_clock;
    logic target_emu_data_out;
    logic target_emu_data_oe;
  } tfp_emu_s;
  typedef struct packed {
    logic active;
    logic pass;
    logic fail;
  } tfp_ate_s;
  typedef struct packed {
    logic red;
    logic green;
  } tfp_led_s;
endpackage : tfp_pkg

/* File: hdl/tfp_pulse_qual.sv */
// Pin synchroniser with pulse-length qualification.
// Assumes pin_i is asynchronous; MIN_CYC is at least 2.
module tfp_pulse_qual #(
  parameter int unsigned MIN_CYC = 3000000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic long_o,
  output logic release_o
);
  localparam int unsigned W = $clog2(MIN_CYC + 1);
  localparam logic [W-1:0] MAXC = W'(MIN_CYC);
  logic s1;
  logic s2;
  logic s3;
  logic [W-1:0] cnt;
  logic held;
  logic agree;

  assign held = (cnt == MAXC);
  assign agree = (s2 == s3);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      level_o <= 1'b0;
      rise_o <= 1'b0;
      release_o <= 1'b0;
    end
    else
    begin
      if (agree)
        level_o <= s3;
      rise_o <= agree && s3 && !level_o;
      release_o <= agree && !s3 && level_o && held;
    end
  end

  // Saturating hold timer, restarts whenever the level drops
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt <= '0;
      long_o <= 1'b0;
    end
    else
    begin
      long_o <= level_o && (cnt == MAXC - 1'b1);
      if (!level_o)
        cnt <= '0;
      else if (!held)
        cnt <= cnt + 1'b1;
    end
  end

  a_release_held:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      release_o |-> $past(held) && !level_o)
    else $error("release seen without full hold");
  a_long_after_rise:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(level_o) |-> !long_o [*2])
    else $error("long pulse too early");
endmodule : tfp_pulse_qual

/* File: hdl/tfp_buzzer.sv */
// Buzzer sequencer: a burst of equal beeps and gaps, one tick each.
// Assumes tick_i is a one-cycle enable from a divider.
module tfp_buzzer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic [2:0] count_i,
  output logic buzz_o,
  output logic busy_o
);
  logic [3:0] rem;
  logic [2:0] beeps;
  logic [2:0] want;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rem <= 4'h0;
      buzz_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else if (start_i)
    begin
      rem <= {count_i, 1'b0};
      buzz_o <= 1'b0;
      busy_o <= (count_i != 3'h0);
    end
    else if (tick_i && rem != 4'h0)
    begin
      rem <= rem - 4'h1;
      buzz_o <= ~buzz_o;
      busy_o <= (rem != 4'h1);
    end
  end

  // Beep tally for the check below only
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || start_i)
      beeps <= 3'h0;
    else if (tick_i && rem != 4'h0 && !buzz_o)
      beeps <= beeps + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      want <= 3'h0;
    else if (start_i)
      want <= count_i;
  end

  a_beep_total:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(busy_o) |-> beeps == want && !buzz_o)
    else $error("wrong number of beeps");
endmodule : tfp_buzzer

/* File: hdl/tfp_prog_ctrl.sv */
// Stand-alone programmer control: test-equipment handshake, pushbutton,
// status LED, buzzer and target programming port.
// Assumes the programming engine runs on clk_i and reports done/ok.
//
// Functional notes
// - Refuse targets whose flash exceeds 512KB.
// - Secure variant: engine encrypts stored firmware with AES ECB.
// - Pushbutton mode starts only program-and-verify, no host needed.
// - Enumeration failure: alternate LED, five beeps 300ms apart.
// - LED alternates red/green while the operation runs.
// - Success leaves LED steady green.
// - Failure leaves LED red and sounds three beeps.
// - Programming-interface enable is driven high to enable target.
// - Target emulation data line is bidirectional.
// - Optional mux line is not needed for programming.
// - Test-equipment mode allows only program or verify.
// - Reset input is an active-low hardware reset.
// - Active output is high while programming and verifying.
// - Pass output goes high after correct program and verify.
// - Pass output drops when start is raised again.
// - Fail output goes high when programming or verify fails.
// - Fail output drops when start is raised again.
// - Allowance decrements per success; zero refuses operations.
// - Total-pass count increments on each success.
// - Total-fail count increments on each failure; counts engine failures only, not refusals.
`include "tfp_regs.svh"
module tfp_prog_ctrl #(
  parameter int unsigned BEEP_CYC = `TFP_MS_CYC(`TFP_BEEP_MS),
  parameter int unsigned BUTTON_CYC = `TFP_MS_CYC(`TFP_BUTTON_MS),
  parameter int unsigned START_CYC = `TFP_MS_CYC(`TFP_START_MS)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ate_start_i,
  input wire logic button_i,
  input wire logic usb_enum_fail_i,
  input wire logic ate_mode_i,
  input wire logic ate_verify_i,
  input wire logic secure_i,
  input wire logic [9:0] flash_kb_i,
  input wire logic allow_load_i,
  input wire logic [31:0] allow_val_i,
  input wire logic eng_done_i,
  input wire logic eng_ok_i,
  input wire logic eng_tx_i,
  input wire logic eng_drive_i,
  input wire logic target_emu_data_in_i,
  output tfp_pkg::tfp_ate_s ate_o,
  output tfp_pkg::tfp_led_s led_o,
  output logic buzzer_o,
  output tfp_pkg::tfp_emu_s emu_o,
  output logic optional_mux_line_o,
  output logic eng_start_o,
  output tfp_pkg::tfp_op_e eng_op_o,
  output logic eng_encrypt_o,
  output logic eng_rx_o,
  output logic [31:0] allow_o,
  output logic [31:0] pass_cnt_o,
  output logic [31:0] fail_cnt_o
);
  import tfp_pkg::*;
  localparam int unsigned TW = $clog2(BEEP_CYC);
  tfp_state_e state;
  tfp_state_e next_state;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic phase;
  logic [3:0] tclk_cnt;
  logic start_rise;
  logic start_long;
  logic btn_release;
  logic rx_level;
  logic req;
  logic refuse;
  logic done_ok;
  logic done_bad;
  logic buz_go;
  logic [2:0] buz_cnt;
  logic buz_busy;
  logic buz_out;
  logic to_fail;
  // qualifies both triggers; set their lengths
  tfp_pulse_qual #(.MIN_CYC(START_CYC)) u_start_q (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(ate_start_i),
    .level_o(),
    .rise_o(start_rise),
    .long_o(start_long),
    .release_o()
  );
  tfp_pulse_qual #(.MIN_CYC(BUTTON_CYC)) u_button_q (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(button_i),
    .level_o(),
    .rise_o(),
    .long_o(),
    .release_o(btn_release)
  );
  // Data coming back from the target is an asynchronous pin too
  tfp_pulse_qual #(.MIN_CYC(2)) u_rx_q (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i(target_emu_data_in_i),
    .level_o(rx_level),
    .rise_o(),
    .long_o(),
    .release_o()
  );
  tfp_buzzer u_buzzer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick),
    .start_i(buz_go),
    .count_i(buz_cnt),
    .buzz_o(buz_out),
    .busy_o(buz_busy)
  );
  // Active tells the equipment to drop start; a held start is taken once
  assign req = ate_mode_i ? start_long : btn_release;
  assign refuse = (flash_kb_i > `TFP_MAX_FLASH_KB)
    || (allow_o == 32'h0000_0000);
  assign done_ok = (state == ST_PROG) && eng_done_i && eng_ok_i;
  assign done_bad = (state == ST_PROG) && eng_done_i && !eng_ok_i;
  // A refusal while already failed must still raise fail and beep again
  assign to_fail = (next_state == ST_FAIL) && (state != ST_FAIL || req);
  assign tick = (tick_cnt == TW'(BEEP_CYC - 1));
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (usb_enum_fail_i)
          next_state = ST_BOOT;
      ST_BOOT:
        if (!buz_go && !buz_busy)
          next_state = ST_READY;
      ST_READY, ST_PASS, ST_FAIL:
        if (req)
          next_state = refuse ? ST_FAIL : ST_PROG;
      ST_PROG:
        if (eng_done_i)
          next_state = eng_ok_i ? ST_PASS : ST_FAIL;
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      buz_go <= 1'b0;
      buz_cnt <= 3'h0;
      buzzer_o <= 1'b0;
    end
    else
    begin
      buz_go <= 1'b0;
      buzzer_o <= buz_out;
      if (state == ST_IDLE && next_state == ST_BOOT)
      begin
        buz_go <= 1'b1;
        buz_cnt <= `TFP_BOOT_BEEPS;
      end
      else if (to_fail)
      begin
        buz_go <= 1'b1;
        buz_cnt <= `TFP_FAIL_BEEPS;
      end
    end
  end
  // Status LED; in boot and programming the colour swaps on every beep tick
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      phase <= 1'b0;
      led_o <= '0;
    end
    else
    begin
      if (tick)
        phase <= ~phase;
      case (next_state)
        ST_BOOT, ST_PROG:
          led_o <= '{red: ~phase, green: phase};
        ST_PASS:
          led_o <= '{red: 1'b0, green: 1'b1};
        ST_FAIL:
          led_o <= '{red: 1'b1, green: 1'b0};
        default:
          led_o <= '0;
      endcase
    end
  end
  // Handshake; a result setting in the cycle of a new start wins
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ate_o <= '0;
    else
    begin
      ate_o.active <= (next_state == ST_PROG);
      if (next_state == ST_PASS && state != ST_PASS)
        ate_o.pass <= 1'b1;
      else if (start_rise)
        ate_o.pass <= 1'b0;
      if (to_fail)
        ate_o.fail <= 1'b1;
      else if (start_rise)
        ate_o.fail <= 1'b0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      allow_o <= `TFP_ALLOW_RST;
      pass_cnt_o <= 32'h0000_0000;
      fail_cnt_o <= 32'h0000_0000;
    end
    else
    begin
      if (done_ok)
      begin
        allow_o <= allow_o - 32'h0000_0001;
        pass_cnt_o <= pass_cnt_o + 32'h0000_0001;
      end
      else if (allow_load_i && state != ST_PROG)
        allow_o <= allow_val_i;
      if (done_bad)
        fail_cnt_o <= fail_cnt_o + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      eng_start_o <= 1'b0;
      eng_op_o <= OP_PROGRAM;
      eng_encrypt_o <= 1'b0;
    end
    else
    begin
      eng_start_o <= (state != ST_PROG) && (next_state == ST_PROG);
      if (state != ST_PROG && next_state == ST_PROG)
        eng_op_o <= (ate_mode_i && ate_verify_i) ? OP_VERIFY : OP_PROGRAM;
      eng_encrypt_o <= secure_i;
    end
  end
  // Target port; the emulation clock only runs during an operation
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      emu_o <= '0;
      tclk_cnt <= 4'h0;
      eng_rx_o <= 1'b0;
      optional_mux_line_o <= 1'b0;
    end
    else
    begin
      optional_mux_line_o <= 1'b0;
      emu_o.prog_if_enable <= (next_state == ST_PROG);
      if (next_state != ST_PROG || tclk_cnt == `TFP_TCLK_HALF - 4'h1)
        tclk_cnt <= 4'h0;
      else
        tclk_cnt <= tclk_cnt + 4'h1;
      if (next_state != ST_PROG)
        emu_o.target_emu_clock <= 1'b0;
      else if (tclk_cnt == `TFP_TCLK_HALF - 4'h1)
        emu_o.target_emu_clock <= ~emu_o.target_emu_clock;
      emu_o.target_emu_data_out <= eng_tx_i;
      emu_o.target_emu_data_oe <= (next_state == ST_PROG) && eng_drive_i;
      eng_rx_o <= rx_level;
    end
  end
  a_active_cause:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(ate_o.active) |-> $past(req) && !$past(refuse))
    else $error("active raised without accepted request");
  a_pass_result:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      done_ok |=> ate_o.pass && !ate_o.active && led_o.green)
    else $error("pass not shown after success");
  a_fail_result:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      done_bad |=> ate_o.fail && led_o.red ##1 buz_busy)
    else $error("fail not shown after failure");
  a_pass_clear:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      start_rise && !done_ok && !(req && refuse) |=> !ate_o.pass)
    else $error("pass kept after new start");
  a_fail_clear:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      start_rise && !done_bad && !req |=> !ate_o.fail)
    else $error("fail kept after new start");
  a_pass_count:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      done_ok |=> pass_cnt_o == $past(pass_cnt_o) + 32'h0000_0001
        && allow_o == $past(allow_o) - 32'h0000_0001)
    else $error("pass count or allowance not updated");
  a_fail_count:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      done_bad |=> fail_cnt_o == $past(fail_cnt_o) + 32'h0000_0001)
    else $error("fail count not updated");
  a_allow_zero:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      state != ST_PROG && allow_o == 32'h0000_0000 |=> state != ST_PROG)
    else $error("operation started with zero allowance");
  a_enable_prog:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state == ST_PROG) |-> emu_o.prog_if_enable && ate_o.active)
    else $error("target port not enabled during operation");
  a_button_in_ate:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      ate_mode_i && !start_long && state == ST_READY |=> state == ST_READY)
    else $error("test-equipment mode took another trigger");
  a_mux_quiet:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      !optional_mux_line_o)
    else $error("optional mux line driven");
endmodule : tfp_prog_ctrl

/* File: test/tfp_engine_model.sv */
// Model of the programming engine and of the target's data pin.
// Assumes it shares clk_i and rstn_i with the control block.
module tfp_engine_model #(
  parameter int unsigned RUN_CYC = 60
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic ok_sel_i,
  input wire logic dev_oe_i,
  input wire logic dev_data_i,
  output logic done_o,
  output logic ok_o,
  output logic tx_o,
  output logic drive_o,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned left;
  logic tgt_bit;
  logic [2:0] div;
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    // Slow transmit data so the three-flop input path can follow it
    div <= div + 3'h1;
    tx_o <= tx_o ^ (div == 3'h7);
    // The target flips its own bit so a released line never looks held
    tgt_bit <= ~tgt_bit;
    drive_o <= (left > 1);
    if (!rstn_i)
    begin
      left <= 0;
      ok_o <= 1'b0;
      tx_o <= 1'b0;
      drive_o <= 1'b0;
      tgt_bit <= 1'b0;
      div <= 3'h0;
    end
    else if (start_i)
      left <= RUN_CYC;
    else if (left == 1)
    begin
      done_o <= 1'b1;
      ok_o <= ok_sel_i;
      left <= 0;
    end
    else if (left > 1)
      left <= left - 1;
  end
  assign line_o = dev_oe_i ? dev_data_i : tgt_bit;
endmodule : tfp_engine_model

/* File: test/test_tfp_prog_ctrl.sv */
// Self-checking bench for the programmer control block.
// Assumes tfp_engine_model stands in for engine and target; counts shortened.
module test_tfp_prog_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import tfp_pkg::*;
  logic clk_i, rstn_i, ate_start_i, button_i, usb_enum_fail_i;
  logic ate_mode_i, ate_verify_i, secure_i, allow_load_i, ok_sel;
  logic eng_done, eng_ok, eng_tx, eng_drive, line, buzz, mux, eng_start;
  logic encrypt, rx;
  logic [9:0] flash_kb;
  logic [31:0] allow_val, allow_o, pass_cnt, fail_cnt;
  tfp_ate_s ate;
  tfp_led_s led;
  tfp_emu_s emu;
  tfp_op_e op;
  int err_total = 0;
  int check_count = 0;

  tfp_prog_ctrl #(.BEEP_CYC(20), .BUTTON_CYC(10), .START_CYC(16)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ate_start_i(ate_start_i),
    .button_i(button_i), .usb_enum_fail_i(usb_enum_fail_i),
    .ate_mode_i(ate_mode_i), .ate_verify_i(ate_verify_i),
    .secure_i(secure_i), .flash_kb_i(flash_kb),
    .allow_load_i(allow_load_i), .allow_val_i(allow_val),
    .eng_done_i(eng_done), .eng_ok_i(eng_ok), .eng_tx_i(eng_tx),
    .eng_drive_i(eng_drive), .target_emu_data_in_i(line), .ate_o(ate),
    .led_o(led), .buzzer_o(buzz), .emu_o(emu), .optional_mux_line_o(mux),
    .eng_start_o(eng_start), .eng_op_o(op), .eng_encrypt_o(encrypt),
    .eng_rx_o(rx), .allow_o(allow_o), .pass_cnt_o(pass_cnt),
    .fail_cnt_o(fail_cnt));

  tfp_engine_model #(.RUN_CYC(60)) eng (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(eng_start), .ok_sel_i(ok_sel),
    .dev_oe_i(emu.target_emu_data_oe), .dev_data_i(emu.target_emu_data_out),
    .done_o(eng_done), .ok_o(eng_ok), .tx_o(eng_tx), .drive_o(eng_drive),
    .line_o(line));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  task automatic wait_act(input int n, output logic took);
    took = 1'b0;
    for (int i = 0; i < n && !took; i++)
    begin
      tick(1);
      took = ate.active;
    end
  endtask : wait_act

  task automatic ate_req(output logic took);
    ate_start_i = 1'b1;
    tick(8);
    check({ate.pass, ate.fail}, 2'b00);
    wait_act(40, took);
    ate_start_i = 1'b0;
  endtask : ate_req

  task automatic press(input int n, output logic took);
    button_i = 1'b1;
    tick(n);
    button_i = 1'b0;
    wait_act(30, took);
  endtask : press

  task automatic count_beeps(input int n, output int b, output logic r, g);
    logic prev;
    b = 0;
    r = 1'b0;
    g = 1'b0;
    prev = 1'b0;
    repeat (n)
    begin
      tick(1);
      b += int'(buzz && !prev);
      prev = buzz;
      r |= led.red;
      g |= led.green;
    end
  endtask : count_beeps

  // Data pins lag the engine by one cycle, so compare against last sample
  task automatic watch_op();
    logic pt, pd, pc, pl, r, g;
    int tog, st;
    pt = eng_tx;
    pd = eng_drive;
    pc = emu.target_emu_clock;
    r = 1'b0;
    g = 1'b0;
    tog = 0;
    st = 0;
    pl = line;
    for (int i = 0; i < 300; i++)
    begin
      tick(1);
      if (!ate.active)
        break;
      r |= led.red;
      g |= led.green;
      tog += int'(emu.target_emu_clock != pc);
      pc = emu.target_emu_clock;
      check({emu.target_emu_data_out, emu.target_emu_data_oe}, {pt, pd});
      check(emu.prog_if_enable, 1'b1);
      pt = eng_tx;
      pd = eng_drive;
      // Line input reaches rx five edges after it settles
      st = (line == pl) ? st + 1 : 0;
      pl = line;
      if (st > 5)
        check(rx, line);
    end
    check({r, g}, 2'b11);
    check(tog > 4, 1'b1);
    check(ate.active, 1'b0);
  endtask : watch_op

  task automatic t_reset();
    check({ate, led, buzz, emu, mux}, 0);
    check(allow_o, 32'h000F4240);
    check(pass_cnt | fail_cnt, 32'h0);
  endtask : t_reset

  task automatic t_boot();
    int b;
    logic r, g;
    usb_enum_fail_i = 1'b1;
    count_beeps(400, b, r, g);
    check(b, 5);
    check({r, g, led.red, led.green}, 4'hC);
  endtask : t_boot

  task automatic t_ate_ops();
    logic took;
    int b;
    logic r, g;
    ate_mode_i = 1'b1;
    secure_i = 1'b1;
    ok_sel = 1'b1;
    ate_req(took);
    check({took, op, encrypt}, 3'b101);
    watch_op();
    check({ate.pass, ate.fail, led.red, led.green}, 4'h9);
    check(pass_cnt, 32'h1);
    check(allow_o, 32'h000F423F);
    ate_verify_i = 1'b1;
    secure_i = 1'b0;
    ok_sel = 1'b0;
    ate_req(took);
    check({took, op, encrypt}, 3'b110);
    watch_op();
    check({ate.pass, ate.fail, led.red, led.green}, 4'h6);
    check(fail_cnt, 32'h1);
    check(allow_o, 32'h000F423F);
    count_beeps(200, b, r, g);
    check(b, 3);
  endtask : t_ate_ops

  task automatic t_refuse();
    logic took;
    ate_start_i = 1'b1;
    tick(6);
    ate_start_i = 1'b0;
    wait_act(60, took);
    check({took, ate.fail}, 2'b00);
    flash_kb = 10'h201;
    ate_req(took);
    check({took, ate.fail}, 2'b01);
    check(fail_cnt, 32'h1);
    flash_kb = 10'h200;
    allow_val = 32'h0;
    allow_load_i = 1'b1;
    tick(2);
    allow_load_i = 1'b0;
    check(allow_o, 32'h0);
    ate_req(took);
    check({took, ate.fail}, 2'b01);
    allow_val = 32'h2;
    allow_load_i = 1'b1;
    tick(1);
    allow_load_i = 1'b0;
  endtask : t_refuse

  task automatic t_button();
    logic took;
    ate_mode_i = 1'b0;
    ok_sel = 1'b1;
    ate_start_i = 1'b1;
    wait_act(40, took);
    ate_start_i = 1'b0;
    check(took, 1'b0);
    press(5, took);
    check(took, 1'b0);
    press(20, took);
    check({took, op}, 2'b10);
    watch_op();
    check({led.red, led.green}, 2'b01);
    check(pass_cnt, 32'h2);
    check(allow_o, 32'h1);
    press(20, took);
    check(took, 1'b1);
    rstn_i = 1'b0;
    tick(4);
    t_reset();
    rstn_i = 1'b1;
  endtask : t_button

  initial
  begin
    #(100 * 20000);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    rstn_i = 1'b0;
    {ate_start_i, button_i, usb_enum_fail_i, ate_mode_i} = 4'h0;
    {ate_verify_i, secure_i, allow_load_i, ok_sel} = 4'h0;
    flash_kb = 10'h200;
    allow_val = 32'h0;
    tick(10);
    rstn_i = 1'b1;
    tick(1);
    t_reset();
    t_boot();
    t_ate_ops();
    t_refuse();
    t_button();
    report_and_stop();
  end
endmodule : test_tfp_prog_ctrl
